// File: rtl/intflag_params.svh
/*
 Offsets, field positions, masks and reset values of the interrupt flag bank.
 Assumes an 8-bit register port with a 4-bit word address.
*/
`ifndef INTFLAG_PARAMS_SVH
`define INTFLAG_PARAMS_SVH

// --------------------------------------------------------------------
// Register map
// --------------------------------------------------------------------
`define ADDR_W 4
`define OFS_GLOBAL_CTRL 4'h0
`define OFS_REQ_BASE 4'h1
`define OFS_EN_BASE 4'h6
`define NUM_BANKS 5

// --------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------
`define BIT_GIE 7
`define BIT_PERIPHERAL_INTERRUPT_ENABLE 6
`define BIT_EDGE 0
`define BIT_EXT_INT 0
`define BIT_WG2 7
`define BIT_WG1 6
`define BIT_T5_GATE 5
`define BIT_T5_OVF 4

// --------------------------------------------------------------------
// Implemented bits and reset values
// --------------------------------------------------------------------
`define MASK_GLOBAL_CTRL 8'hc1
`define MASK_BANK0 8'h31
`define MASK_FULL 8'hff
`define RST_GLOBAL_CTRL 8'h00
`define RST_FLAGS 8'h00
`define RST_ENABLE 8'h00

`endif

// File: rtl/intflag_pkg.sv
/*
 Types shared by the interrupt flag bank.
 Assumes intflag_params.svh is on the include path.
*/
`include "intflag_params.svh"

package intflag_pkg;

    typedef enum logic [1:0] {CCP_OFF, CCP_CAPTURE, CCP_COMPARE, CCP_PWM} ccp_mode_type;

    typedef struct packed {
        ccp_mode_type mode;
        logic capture;
        logic match;
        logic pwm_out;
    } ccp_event_type;

    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [`NUM_BANKS-1:0][7:0] req;
        logic [`NUM_BANKS-1:0][7:0] en;
        logic [2:0] pin_sync;
        logic pin_lvl;
        logic [1:0] wg_prev;
        logic gate_prev;
        logic [3:0] pwm_prev;
        logic [7:0] rd_data;
        logic irq;
    } state_type;

endpackage

// File: rtl/peripheral_interrupt_flag_bank.sv
/*
 Peripheral interrupt flag bank: global control, five request banks and five
 enable banks, with event detection for bank 4 and the external pin.
 Assumes event inputs come from logic on REF_CLK, except EXT_INT_PIN which is
 asynchronous. Register port answers reads one cycle later and never stalls.
*/
// The placing of the registers and strobed register access were chosen for this implementation.
// Functional notes
// - Bank 4 flags read/write, hardware set, reset 0
// - Generator 2 shutdown sets bit 7
// - Generator 1 shutdown sets bit 6
// - Timer 5 gate closing sets bit 5
// - Timer 5 overflow sets bit 4, held
// - Capture event sets unit flag, held
// - Compare match sets unit flag, held
// - PWM trailing edge sets unit flag
// - Flags set regardless of any enable
// - Enable banks mirror request bank layout
// - Unimplemented bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none
`include "intflag_params.svh"

module peripheral_interrupt_flag_bank (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire intflag_pkg::reg_req_type BUS,
    output logic [7:0] RD_DATA,
    input wire logic [3:0][7:0] EVT_REQ,
    input wire logic EXT_INT_PIN,
    input wire logic [1:0] WG_SHUTDOWN,
    input wire logic T5_GATE,
    input wire logic T5_OVERFLOW,
    input wire intflag_pkg::ccp_event_type [3:0] CCP,
    output logic IRQ
);
    import intflag_pkg::*;

    // --------------------------------------------------------------------
    // Reset release
    // --------------------------------------------------------------------
    logic [1:0] rst_pipe_r;
    logic rst_n_sync;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_pipe_r <= 2'b00;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_n_sync = rst_pipe_r[1];

    // --------------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------------
    // implemented bit masks
    function automatic logic [7:0] bank_mask(input int idx);
        if (idx == 0) begin
            return `MASK_BANK0;
        end
        return `MASK_FULL;
    endfunction

    function automatic logic [7:0] read_mux(input state_type st, input logic [`ADDR_W-1:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == `OFS_GLOBAL_CTRL) begin
            v = st.ctrl;
        end
        for (int i = 0; i < `NUM_BANKS; i++) begin
            if (a == `ADDR_W'(`OFS_REQ_BASE + i)) begin
                v = st.req[i];
            end
            if (a == `ADDR_W'(`OFS_EN_BASE + i)) begin
                v = st.en[i];
            end
        end
        return v;
    endfunction

    function automatic logic irq_of(input state_type st);
        logic core_hit;
        logic periph_hit;
        core_hit = |(st.req[0] & st.en[0]);
        periph_hit = 1'b0;
        for (int i = 1; i < `NUM_BANKS; i++) begin
            periph_hit = periph_hit | (|(st.req[i] & st.en[i]));
        end
        return st.ctrl[`BIT_GIE] & (core_hit | (st.ctrl[`BIT_PERIPHERAL_INTERRUPT_ENABLE] & periph_hit));
    endfunction

    // --------------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------------
    state_type s_r;
    state_type s_nxt;
    logic [`NUM_BANKS-1:0][7:0] set_v;
    logic pin_stable;
    logic ext_edge;

    always_comb begin
        s_nxt = s_r;
        set_v = '0;
        s_nxt.pin_sync = {s_r.pin_sync[1:0], EXT_INT_PIN};
        // Level accepted only once second and third stage agree
        pin_stable = (s_r.pin_sync[1] == s_r.pin_sync[2]);
        ext_edge = pin_stable && (s_r.pin_sync[2] != s_r.pin_lvl) &&
            (s_r.pin_sync[2] == s_r.ctrl[`BIT_EDGE]);
        if (pin_stable) begin
            s_nxt.pin_lvl = s_r.pin_sync[2];
        end
        set_v[0] = EVT_REQ[0] & `MASK_BANK0;
        set_v[0][`BIT_EXT_INT] = set_v[0][`BIT_EXT_INT] | ext_edge;
        for (int i = 1; i < 4; i++) begin
            set_v[i] = EVT_REQ[i];
        end
        set_v[4][`BIT_WG2] = WG_SHUTDOWN[1] & ~s_r.wg_prev[1];
        set_v[4][`BIT_WG1] = WG_SHUTDOWN[0] & ~s_r.wg_prev[0];
        set_v[4][`BIT_T5_GATE] = s_r.gate_prev & ~T5_GATE;
        set_v[4][`BIT_T5_OVF] = T5_OVERFLOW;
        for (int i = 0; i < 4; i++) begin
            case (CCP[i].mode)
                CCP_CAPTURE: begin
                    set_v[4][i] = CCP[i].capture;
                end
                CCP_COMPARE: begin
                    set_v[4][i] = CCP[i].match;
                end
                CCP_PWM: begin
                    set_v[4][i] = s_r.pwm_prev[i] & ~CCP[i].pwm_out;
                end
                default: begin
                    set_v[4][i] = 1'b0;
                end
            endcase
            s_nxt.pwm_prev[i] = CCP[i].pwm_out;
        end
        s_nxt.wg_prev = WG_SHUTDOWN;
        s_nxt.gate_prev = T5_GATE;
        if (BUS.wr) begin
            if (BUS.addr == `OFS_GLOBAL_CTRL) begin
                s_nxt.ctrl = BUS.wdata & `MASK_GLOBAL_CTRL;
            end
            for (int i = 0; i < `NUM_BANKS; i++) begin
                if (BUS.addr == `ADDR_W'(`OFS_REQ_BASE + i)) begin
                    s_nxt.req[i] = BUS.wdata & bank_mask(i);
                end
                // enable bank i matches request bank i
                if (BUS.addr == `ADDR_W'(`OFS_EN_BASE + i)) begin
                    s_nxt.en[i] = BUS.wdata & bank_mask(i);
                end
            end
        end
        // hardware set beats a same-cycle software clear
        for (int i = 0; i < `NUM_BANKS; i++) begin
            s_nxt.req[i] = s_nxt.req[i] | set_v[i];
        end
        s_nxt.rd_data = BUS.rd ? read_mux(s_r, BUS.addr) : 8'h00;
        s_nxt.irq = irq_of(s_nxt);
    end

    always_ff @(posedge REF_CLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            s_r <= '0;
            s_r.ctrl <= `RST_GLOBAL_CTRL;
            s_r.req <= {`NUM_BANKS{`RST_FLAGS}};
            s_r.en <= {`NUM_BANKS{`RST_ENABLE}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign RD_DATA = s_r.rd_data;
    assign IRQ = s_r.irq;

    // --------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!rst_n_sync);

    logic wr_req4;
    assign wr_req4 = BUS.wr && (BUS.addr == `ADDR_W'(`OFS_REQ_BASE + 4));

    sequence s_pwm_fall;
        (CCP[0].mode == CCP_PWM) && $fell(CCP[0].pwm_out);
    endsequence

    sequence s_capture_hit;
        (CCP[1].mode == CCP_CAPTURE) && CCP[1].capture;
    endsequence

    a_reset_clear: assert property ($rose(rst_n_sync) |-> s_r.req[4] == 8'h00)
        else $error("bank 4 flags not clear after reset");
    a_wavegen2_set: assert property ($rose(WG_SHUTDOWN[1]) |=> s_r.req[4][7])
        else $error("generator 2 shutdown flag not set");
    a_wavegen1_set: assert property ($rose(WG_SHUTDOWN[0]) |=> s_r.req[4][6])
        else $error("generator 1 shutdown flag not set");
    a_gate_close: assert property ($fell(T5_GATE) |=> s_r.req[4][5])
        else $error("timer gate flag not set on close");
    a_overflow_hold: assert property (s_r.req[4][4] && !wr_req4 |=> s_r.req[4][4])
        else $error("overflow flag dropped without a write");
    a_capture_set: assert property (s_capture_hit |=> s_r.req[4][1] [*2])
        else $error("capture flag not set or not held");
    a_compare_set: assert property ((CCP[2].mode == CCP_COMPARE) && CCP[2].match
        && !wr_req4 |=> s_r.req[4][2])
        else $error("compare flag not set");
    a_pwm_trail: assert property (s_pwm_fall |=> s_r.req[4][0])
        else $error("trailing edge flag not set");
    a_enable_free: assert property (EVT_REQ[1][0] && !s_r.en[1][0] |=> s_r.req[1][0])
        else $error("flag gated by its enable");
    a_read_mirror: assert property (BUS.rd && BUS.addr == `OFS_EN_BASE + 4'h4
        |=> RD_DATA == $past(s_r.en[4]))
        else $error("enable bank read mismatch");
    a_unimpl_zero: assert property (((s_r.ctrl & ~`MASK_GLOBAL_CTRL) == 8'h00)
        && ((s_r.req[0] & ~`MASK_BANK0) == 8'h00))
        else $error("unimplemented bit set");
    a_irq_gate: assert property (!s_r.ctrl[`BIT_GIE] || !(|(s_r.req[0] & s_r.en[0])
        | (s_r.ctrl[`BIT_PERIPHERAL_INTERRUPT_ENABLE] & (|(s_r.req[4] & s_r.en[4])))) ? 1'b1 : IRQ)
        else $error("request missing while enabled");
    a_irq_quiet: assert property (!s_r.ctrl[`BIT_GIE] |-> !IRQ)
        else $error("request raised with global enable off");

endmodule
`default_nettype wire

// File: dv/event_source_model.sv
/*
 Behavioural peripheral event sources for bank 4: generator shutdown levels,
 timer 5 gate and overflow, and four capture/compare/PWM units.
 Assumes one clock shared with the flag bank; fire() is called by the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module event_source_model
(
    input wire logic clk,
    output logic [1:0] wg_shutdown,
    output logic t5_gate,
    output logic t5_overflow,
    output intflag_pkg::ccp_event_type [3:0] ccp
);
    import intflag_pkg::*;

    // ----------------------------------------------------------------
    // Idle levels
    // ----------------------------------------------------------------
    // Gate idles open and PWM output idles high, so only fire() makes edges
    initial begin
        wg_shutdown = 2'b00;
        t5_gate = 1'b1;
        t5_overflow = 1'b0;
        for (int i = 0; i < 4; i++) begin
            ccp[i] = '{CCP_OFF, 1'b0, 1'b0, 1'b1};
        end
    end

    // ----------------------------------------------------------------
    // One event per call
    // ----------------------------------------------------------------
    // Mode is settled one cycle ahead so a mode change never looks like an event
    task automatic fire(input logic [2:0] code, input ccp_mode_type m);
        @(posedge clk);
        if (code < 3'h4) begin
            ccp[code[1:0]].mode <= m;
        end
        @(posedge clk);
        case (code)
            3'h7: wg_shutdown[1] <= 1'b1;
            3'h6: wg_shutdown[0] <= 1'b1;
            3'h5: t5_gate <= 1'b0;
            3'h4: t5_overflow <= 1'b1;
            default: begin
                ccp[code[1:0]].capture <= (m == CCP_CAPTURE) || (m == CCP_OFF);
                ccp[code[1:0]].match <= (m == CCP_COMPARE);
                ccp[code[1:0]].pwm_out <= (m != CCP_PWM);
            end
        endcase
        @(posedge clk);
        wg_shutdown <= 2'b00;
        t5_gate <= 1'b1;
        t5_overflow <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            ccp[i].capture <= 1'b0;
            ccp[i].match <= 1'b0;
            ccp[i].pwm_out <= 1'b1;
        end
    endtask
endmodule

`default_nettype wire

// File: dv/test_peripheral_interrupt_flag_bank.sv
/*
 Self-checking bench for the interrupt flag bank: register access, event
 flags, interrupt gating and the external pin.
 Assumes the package, the design and the event source model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module test_peripheral_interrupt_flag_bank;
    import intflag_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ext = 1'b0;
    reg_req_type bus = '0;
    logic [3:0][7:0] evt = '0;
    logic [7:0] rd_data;
    logic irq;
    logic [1:0] wg_shutdown;
    logic t5_gate;
    logic t5_overflow;
    ccp_event_type [3:0] ccp;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #2.5 clk = ~clk;

    peripheral_interrupt_flag_bank u_peripheral_interrupt_flag_bank (
        .REF_CLK(clk), .RST_N(rst_n), .BUS(bus), .RD_DATA(rd_data), .EVT_REQ(evt),
        .EXT_INT_PIN(ext), .WG_SHUTDOWN(wg_shutdown), .T5_GATE(t5_gate),
        .T5_OVERFLOW(t5_overflow), .CCP(ccp), .IRQ(irq));

    event_source_model u_event_source_model (.clk(clk), .wg_shutdown(wg_shutdown),
        .t5_gate(t5_gate), .t5_overflow(t5_overflow), .ccp(ccp));

    // ----------------------------------------------------------------
    // Checks and bus cycles
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input int a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{4'(a), d, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input int a, input logic [7:0] e);
        @(posedge clk);
        bus <= '{4'(a), 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk("rd_data", e, rd_data);
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        #1;
        chk("irq", {7'h00, e}, {7'h00, irq});
    endtask

    task automatic end_sim;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 16; i++) rd(i, 8'h00);
        wr(0, 8'hff);
        rd(0, 8'hc1);
        wr(1, 8'hff);
        rd(1, 8'h31);
        wr(6, 8'hff);
        rd(6, 8'h31);
        for (int i = 2; i <= 10; i++) begin
            if (i != 6) begin
                wr(i, 8'hff);
                rd(i, 8'hff);
            end
        end
        for (int i = 0; i <= 10; i++) wr(i, 8'h00);
        wr(11, 8'hff);
        rd(11, 8'h00);
        // Flags must set with every enable off
        for (int k = 4; k < 8; k++) begin
            u_event_source_model.fire(3'(k), CCP_OFF);
            rd(5, 8'h01 << k);
            rd(5, 8'h01 << k);
            wr(5, 8'h00);
        end
        for (int u = 0; u < 4; u++) begin
            for (int m = 1; m < 4; m++) begin
                u_event_source_model.fire(3'(u), ccp_mode_type'(m));
                rd(5, 8'h01 << u);
                wr(5, 8'h00);
            end
        end
        u_event_source_model.fire(3'h0, CCP_OFF);
        rd(5, 8'h00);
        @(posedge clk);
        evt <= '1;
        @(posedge clk);
        evt <= '0;
        rd(1, 8'h31);
        for (int i = 2; i <= 4; i++) rd(i, 8'hff);
        for (int i = 1; i <= 4; i++) wr(i, 8'h00);
        // Stale flag cleared before enabling
        u_event_source_model.fire(3'h4, CCP_OFF);
        wr(5, 8'h00);
        wr(10, 8'h10);
        wr(0, 8'h80);
        irq_is(1'b0);
        u_event_source_model.fire(3'h4, CCP_OFF);
        irq_is(1'b0);
        wr(0, 8'hc0);
        irq_is(1'b1);
        wr(10, 8'h00);
        irq_is(1'b0);
        wr(6, 8'h20);
        wr(0, 8'h80);
        @(posedge clk);
        evt[0][5] <= 1'b1;
        @(posedge clk);
        evt[0][5] <= 1'b0;
        irq_is(1'b1);
        // External pin, rising then falling select
        wr(1, 8'h00);
        wr(0, 8'h01);
        ext <= 1'b1;
        repeat (8) @(posedge clk);
        rd(1, 8'h01);
        wr(1, 8'h00);
        wr(0, 8'h00);
        ext <= 1'b0;
        repeat (8) @(posedge clk);
        rd(1, 8'h01);
        end_sim();
    end
endmodule

`default_nettype wire
